// *** pulse_accumulator_regs.svh ***
// register offsets, field positions and reset values of the pulse accumulator
`ifndef PULSE_ACCUMULATOR_REGS_SVH
`define PULSE_ACCUMULATOR_REGS_SVH

// ==========================================
// register byte addresses (index times four)
`define ACC_FLAGS_INDEX      8'h21
`define ACC_FLAGS_ADDR       12'h084
`define ACC_CONTROL_ADDR     12'h080
`define ACC_COUNT_ADDR       12'h088
`define TIMER_CONTROL_ADDR   12'h08C

// ==========================================
// accumulator_control fields
`define CTL_ENABLE_BIT       6
`define CTL_MODE_BIT         5
`define CTL_EDGE_BIT         4
`define CTL_CLKSEL_HI        3
`define CTL_CLKSEL_LO        2
`define CTL_OVF_IRQ_BIT      1
`define CTL_INP_IRQ_BIT      0

// accumulator_flags fields
`define FLG_OVF_BIT          1
`define FLG_INP_BIT          0

// timer control word: enable, fast clear, prescale
`define TMR_ENABLE_BIT       7
`define TMR_FFCA_BIT         4
`define TMR_PRESC_HI         2
`define TMR_PRESC_LO         0

// ==========================================
// reset values and counts
`define CTL_RESET            8'h00
`define TMR_RESET            8'h00
`define COUNT_RESET          16'h0000
`define GATE_DIVIDE_LOG2     6
`define ACCCLK_DIV256_LOG2   8
`define ACCCLK_DIV64K_LOG2   16

`endif

// *** pulse_accumulator_pkg.sv ***
// types shared by the pulse accumulator files
package pulse_accumulator_pkg;
	typedef enum logic [1:0] {
		CLK_PRESCALER,
		CLK_ACC_CLOCK,
		CLK_ACC_DIV256,
		CLK_ACC_DIV64K
	} clock_select_e;
endpackage

// *** prescale_if.sv ***
// prescaler request and tick signals between top and prescaler
`timescale 1ns/10ps
`default_nettype none
interface prescale_if;
	logic       run;
	logic [2:0] select;
	logic       tick;
	logic       tickDiv64;
	modport owner (output run, output select, input tick, input tickDiv64);
	modport divider (input run, input select, output tick, output tickDiv64);
endinterface
`default_nettype wire

// *** timer_prescaler.sv ***
// timer prescaler: bus clock divided by 1..128 and a fixed divide-by-64 tick
`timescale 1ns/10ps
`default_nettype none
module timer_prescaler #(
	parameter int WIDTH = 7
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic clkEnable,
	prescale_if.divider pre
);
	`include "pulse_accumulator_regs.svh"

	logic [WIDTH-1:0] stage;
	logic [2:0]       activeSelect;
	logic [WIDTH-1:0] mask;

	// ==========================================
	// free counter, runs only while the timer is enabled
	always_ff @(posedge clk_sys) begin
		if (rst)
			stage <= '0;
		else if (clkEnable && pre.run)
			stage <= stage + 1'b1;
		else if (clkEnable)
			stage <= '0;
	end

	// new divisor takes hold where all stages are zero
	always_ff @(posedge clk_sys) begin
		if (rst)
			activeSelect <= 3'h0;
		else if (clkEnable && stage == '0)
			activeSelect <= pre.select;
	end

	always_comb begin
		mask = WIDTH'((1 << activeSelect) - 1);
	end

	// no ticks at all while the timer is off
	assign pre.tick      = pre.run && ((stage & mask) == mask);
	assign pre.tickDiv64 = pre.run &&
		(stage[`GATE_DIVIDE_LOG2-1:0] == {`GATE_DIVIDE_LOG2{1'b1}});
endmodule
`default_nettype wire

// *** pulse_accumulator.sv ***
// pulse accumulator with apb registers and timer clock selection
// Overview of operation
// - enable bit works independent of timer
// - mode bit: events or gated time
// - edge bit picks falling or rising
// - gated level admits div64 ticks, trailing flags
// - div64 ticks exist only with timer
// - overflow enable gates overflow interrupt
// - input enable gates input interrupt
// - clock select picks timer counter clock
// - disabled accumulator forces prescaler clock
// - clock select switches immediately
// - rollover ffff to zero sets overflow
// - write ones clear flags
// - selected or trailing edge sets input
// - fast clear: count access clears flags
// - count readable and writable any time
// - count accessed as whole word
// - input synchronised before counting
// - prescaler divides by one to 128
// - shared channel seven pin feeds accumulator
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module pulse_accumulator
	import pulse_accumulator_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        clkEnable,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        channelSevenPin,
	output logic             timerCounterClock,
	output logic             overflowIrq,
	output logic             inputEdgeIrq
);
	import pulse_accumulator_pkg::*;
	`include "pulse_accumulator_regs.svh"

	prescale_if pre ();

	logic [7:0]    accumulatorControl;
	logic [7:0]    timerControl;
	logic [15:0]   accumulatorCount;
	logic          overflowFlag;
	logic          inputEdgeFlag;
	logic          pinMeta;
	logic          pinSync;
	logic          pinLast;
	logic [15:0]   accClockDiv;
	logic          accessPhase;
	logic          wrCtl;
	logic          wrFlg;
	logic          wrCnt;
	logic          wrTmr;
	logic          accessCnt;
	logic          accEnable;
	logic          gatedMode;
	logic          edgeSel;
	logic          riseSeen;
	logic          fallSeen;
	logic          eventEdge;
	logic          gateActive;
	logic          trailingEdge;
	logic          accClock;
	logic          countStep;
	logic          rollover;
	logic          setInput;
	logic          clearOvf;
	logic          clearInp;
	logic          next_overflowFlag;
	logic          next_inputEdgeFlag;
	clock_select_e clockSelect;

	// address match helper used by every decode
	function automatic logic hit(input logic [11:0] addr,
		input logic [11:0] reg_addr);
		hit = (addr[11:2] == reg_addr[11:2]);
	endfunction

	// ==========================================
	// apb decode, zero wait states
	assign accessPhase = psel && penable && clkEnable;
	assign wrCtl       = accessPhase && pwrite && hit(paddr, `ACC_CONTROL_ADDR);
	assign wrFlg       = accessPhase && pwrite && hit(paddr, `ACC_FLAGS_ADDR);
	assign wrCnt       = accessPhase && pwrite && hit(paddr, `ACC_COUNT_ADDR);
	assign wrTmr       = accessPhase && pwrite &&
		hit(paddr, `TIMER_CONTROL_ADDR);
	assign accessCnt   = accessPhase && hit(paddr, `ACC_COUNT_ADDR);
	assign pready      = 1'b1;

	// unmapped addresses answer with an error
	always_comb begin
		pslverr = psel && penable && !(hit(paddr, `ACC_CONTROL_ADDR) ||
			hit(paddr, `ACC_FLAGS_ADDR) || hit(paddr, `ACC_COUNT_ADDR) ||
			hit(paddr, `TIMER_CONTROL_ADDR));
	end

	// read data registered in the setup cycle
	always_ff @(posedge clk_sys) begin
		if (rst)
			prdata <= 32'h00000000;
		else if (clkEnable && psel && !penable && !pwrite) begin
			if (hit(paddr, `ACC_CONTROL_ADDR))
				prdata <= {24'h000000, accumulatorControl};
			else if (hit(paddr, `ACC_FLAGS_ADDR))
				prdata <= {30'h00000000, overflowFlag, inputEdgeFlag};
			else if (hit(paddr, `ACC_COUNT_ADDR))
				prdata <= {16'h0000, accumulatorCount};
			else if (hit(paddr, `TIMER_CONTROL_ADDR))
				prdata <= {24'h000000, timerControl};
			else
				prdata <= 32'h00000000;
		end
	end

	// ==========================================
	// control registers
	always_ff @(posedge clk_sys) begin
		if (rst)
			accumulatorControl <= `CTL_RESET;
		else if (wrCtl)
			accumulatorControl <= {1'b0, pwdata[6:0]};
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			timerControl <= `TMR_RESET;
		else if (wrTmr)
			timerControl <= {pwdata[7], 2'b00, pwdata[4], 1'b0, pwdata[2:0]};
	end

	assign accEnable   = accumulatorControl[`CTL_ENABLE_BIT];
	assign gatedMode   = accEnable && accumulatorControl[`CTL_MODE_BIT];
	assign edgeSel     = accumulatorControl[`CTL_EDGE_BIT];
	assign clockSelect = clock_select_e'(
		accumulatorControl[`CTL_CLKSEL_HI:`CTL_CLKSEL_LO]);

	// prescaler runs from the timer enable only
	assign pre.run    = timerControl[`TMR_ENABLE_BIT];
	assign pre.select = timerControl[`TMR_PRESC_HI:`TMR_PRESC_LO];

	timer_prescaler #(
		.WIDTH (7)
	) u_prescaler (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.clkEnable (clkEnable),
		.pre       (pre)
	);

	// ==========================================
	// pin synchroniser and edge detection
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pinMeta <= 1'b0;
			pinSync <= 1'b0;
			pinLast <= 1'b0;
		end else if (clkEnable) begin
			pinMeta <= channelSevenPin;
			pinSync <= pinMeta;
			pinLast <= pinSync;
		end
	end

	assign riseSeen  = pinSync && !pinLast;
	assign fallSeen  = !pinSync && pinLast;
	assign eventEdge = edgeSel ? riseSeen : fallSeen;
	// active gate level and the edge that ends it
	assign gateActive   = edgeSel ? !pinSync : pinSync;
	assign trailingEdge = edgeSel ? riseSeen : fallSeen;

	// count source per mode; gated ticks need the timer
	assign accClock = !accEnable ? 1'b0 :
		gatedMode ? (gateActive && pre.tickDiv64) : eventEdge;
	assign countStep = clkEnable && accClock && !wrCnt;
	assign rollover  = countStep && (accumulatorCount == 16'hFFFF);
	assign setInput  = clkEnable && accEnable &&
		(gatedMode ? trailingEdge : eventEdge);

	// ==========================================
	// accumulator counter
	always_ff @(posedge clk_sys) begin
		if (rst)
			accumulatorCount <= `COUNT_RESET;
		else if (wrCnt)
			accumulatorCount <= pwdata[15:0];
		else if (countStep)
			accumulatorCount <= accumulatorCount + 16'h0001;
	end

	// ==========================================
	// flags: set wins over any clear
	assign clearOvf = (wrFlg && pwdata[`FLG_OVF_BIT]) ||
		(accessCnt && timerControl[`TMR_FFCA_BIT]);
	assign clearInp = (wrFlg && pwdata[`FLG_INP_BIT]) ||
		(accessCnt && timerControl[`TMR_FFCA_BIT]);

	always_comb begin
		next_overflowFlag = overflowFlag;
		if (clearOvf)
			next_overflowFlag = 1'b0;
		if (rollover)
			next_overflowFlag = 1'b1;
		next_inputEdgeFlag = inputEdgeFlag;
		if (clearInp)
			next_inputEdgeFlag = 1'b0;
		if (setInput)
			next_inputEdgeFlag = 1'b1;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			overflowFlag  <= 1'b0;
			inputEdgeFlag <= 1'b0;
		end else if (clkEnable) begin
			overflowFlag  <= next_overflowFlag;
			inputEdgeFlag <= next_inputEdgeFlag;
		end
	end

	// interrupt requests from flags and enables
	assign overflowIrq  = overflowFlag &&
		accumulatorControl[`CTL_OVF_IRQ_BIT];
	assign inputEdgeIrq = inputEdgeFlag &&
		accumulatorControl[`CTL_INP_IRQ_BIT];

	// ==========================================
	// accumulator clock dividers for the timer counter
	always_ff @(posedge clk_sys) begin
		if (rst)
			accClockDiv <= 16'h0000;
		else if (clkEnable && accClock)
			accClockDiv <= accClockDiv + 16'h0001;
	end

	// combinational select so a new field acts at once
	always_comb begin
		if (!accEnable)
			timerCounterClock = pre.tick;
		else begin
			case (clockSelect)
				CLK_PRESCALER: timerCounterClock = pre.tick;
				CLK_ACC_CLOCK:  timerCounterClock = accClock;
				CLK_ACC_DIV256: timerCounterClock = accClock &&
					(accClockDiv[`ACCCLK_DIV256_LOG2-1:0] == 8'hFF);
				CLK_ACC_DIV64K: timerCounterClock = accClock &&
					(accClockDiv == 16'hFFFF);
				default:       timerCounterClock = pre.tick;
			endcase
		end
	end

	// ==========================================
	// checks
	// overflow flag follows a rollover
	AST_OVF_SET: assert property (
		@(posedge clk_sys) disable iff (rst)
		rollover |=> overflowFlag)
		else $error("overflow flag not set on rollover");

	// interrupt requests are flag and enable
	AST_OVF_IRQ: assert property (
		@(posedge clk_sys) disable iff (rst)
		overflowIrq == (overflowFlag && accumulatorControl[1]))
		else $error("overflow interrupt mismatch");

	AST_INP_IRQ: assert property (
		@(posedge clk_sys) disable iff (rst)
		inputEdgeIrq == (inputEdgeFlag && accumulatorControl[0]))
		else $error("input interrupt mismatch");

	// write one clears, unless a set arrives together
	AST_W1C: assert property (
		@(posedge clk_sys) disable iff (rst)
		(wrFlg && pwdata[0] && !setInput) |=> !inputEdgeFlag)
		else $error("input flag not cleared by write one");

	AST_W1C_OVF: assert property (
		@(posedge clk_sys) disable iff (rst)
		(wrFlg && pwdata[1] && !rollover) |=> !overflowFlag)
		else $error("overflow flag not cleared by write one");

	// fast clear on any count access
	AST_FFCA: assert property (
		@(posedge clk_sys) disable iff (rst)
		(accessCnt && timerControl[4] && !rollover) |=> !overflowFlag)
		else $error("fast clear failed");

	// no gated pulses without the timer
	AST_NO_GATE: assert property (
		@(posedge clk_sys) disable iff (rst)
		(gatedMode && !timerControl[7]) |-> !accClock)
		else $error("gated tick without timer");

	// a disabled accumulator neither counts nor flags
	AST_MODE_OFF: assert property (
		@(posedge clk_sys) disable iff (rst)
		!accEnable |-> (!accClock && !setInput))
		else $error("disabled accumulator active");

	AST_DISABLED: assert property (
		@(posedge clk_sys) disable iff (rst)
		!accEnable |-> (timerCounterClock == pre.tick))
		else $error("disabled accumulator not on prescaler");

	// selected accumulator clock reaches the timer at once
	AST_SEL_NOW: assert property (
		@(posedge clk_sys) disable iff (rst)
		(accEnable && clockSelect == CLK_ACC_CLOCK) |->
		(timerCounterClock == accClock))
		else $error("accumulator clock not selected");

	AST_LOAD: assert property (
		@(posedge clk_sys) disable iff (rst)
		wrCnt |=> (accumulatorCount == $past(pwdata[15:0])))
		else $error("count load failed");

	// selected edges count one each
	AST_EVENT: assert property (
		@(posedge clk_sys) disable iff (rst)
		(clkEnable && accEnable && !gatedMode && !edgeSel && !wrCnt &&
		$fell(pinSync)) |=> accumulatorCount == $past(accumulatorCount)
		+ 16'h0001)
		else $error("falling edge not counted");

	AST_RISE: assert property (
		@(posedge clk_sys) disable iff (rst)
		(clkEnable && accEnable && !gatedMode && edgeSel && !wrCnt &&
		$rose(pinSync)) |=> accumulatorCount == $past(accumulatorCount)
		+ 16'h0001)
		else $error("rising edge not counted");

	// gated pulse counts while the level is active
	AST_GATE_STEP: assert property (
		@(posedge clk_sys) disable iff (rst)
		(clkEnable && gatedMode && gateActive && pre.tickDiv64 &&
		!wrCnt) |=> accumulatorCount == $past(accumulatorCount)
		+ 16'h0001)
		else $error("gated pulse not counted");

	// input flag follows its setting edge
	AST_INP_SET: assert property (
		@(posedge clk_sys) disable iff (rst)
		setInput |=> inputEdgeFlag)
		else $error("input flag not set");

	// main scenarios
	COV_ROLL: cover property (@(posedge clk_sys) rollover);
	COV_GATED: cover property (@(posedge clk_sys) gatedMode && accClock);
	COV_TRAIL: cover property (@(posedge clk_sys) gatedMode && setInput);
	COV_SEL: cover property (@(posedge clk_sys)
		accEnable && clockSelect == CLK_ACC_DIV256 && timerCounterClock);
endmodule
`default_nettype wire

// *** pin_source.sv ***
// stimulus model of the signal source on the shared channel seven pin
`timescale 1ns/10ps
`default_nettype none
module pin_source (
	input  wire logic clk_sys,
	output var logic  pin
);
	// ==========================================
	// pin level driver
	// idle high, the quiet level for falling-edge counting
	initial pin = 1'b1;

	// change level after an edge, hold it well past the synchronizer
	task automatic level(input logic v, input int hold);
		@(posedge clk_sys);
		pin <= v;
		repeat (hold) @(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench of the pulse accumulator
`timescale 1ns/10ps
`default_nettype none
`include "pulse_accumulator_regs.svh"
module tb_top;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        clkEn = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pin;
	logic        tcClk;
	logic        ovfIrq;
	logic        inIrq;
	logic [31:0] expQ[$];
	logic [15:0] v;
	int          fails = 0;
	int          samples_checked = 0;
	int          ticks = 0;
	int          n;

	// ==========================================
	// clock, design and pin source
	always #5 clk_sys = ~clk_sys;

	pulse_accumulator u_pulse_accumulator (
		.clk_sys(clk_sys), .rst(rst), .clkEnable(clkEn),
		.psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .channelSevenPin(pin),
		.timerCounterClock(tcClk), .overflowIrq(ovfIrq),
		.inputEdgeIrq(inIrq)
	);

	pin_source pin_src (.clk_sys(clk_sys), .pin(pin));

	// ==========================================
	// compare, bus and report tasks
	task automatic check(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic [11:0] a, input logic w,
			input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20)
			check("apb ready", 32'h1, 32'h0);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		expQ.push_back(e);
		apb(a, 1'b0, 32'h0);
	endtask

	task automatic tickStart();
		@(negedge clk_sys);
		ticks = 0;
	endtask

	task automatic tickCheck(input logic [31:0] e);
		@(negedge clk_sys);
		check("timer clock ticks", e, ticks);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ==========================================
	// read monitor and timer clock tick counter
	always @(posedge clk_sys) begin
		if (tcClk === 1'b1)
			ticks++;
		if (psel && penable && pready === 1'b1) begin
			check("pslverr", {31'h0, !(paddr inside {`ACC_CONTROL_ADDR,
				`ACC_FLAGS_ADDR, `ACC_COUNT_ADDR, `TIMER_CONTROL_ADDR})},
				{31'h0, pslverr});
			if (!pwrite) begin
				if (expQ.size() == 0)
					check("unexpected read", 32'h0, 32'h1);
				else
					check($sformatf("read %h", paddr), expQ.pop_front(), prdata);
			end
		end
	end

	// watchdog against a hung run
	initial begin
		repeat (100000) @(posedge clk_sys);
		check("watchdog", 32'h0, 32'h1);
		tally_and_finish();
	end

	// ==========================================
	// main sequence
	initial begin
		void'($urandom(47));
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		// reset values, unmapped place, reserved bit
		rd(`ACC_CONTROL_ADDR, 32'h0);
		rd(`ACC_FLAGS_ADDR, 32'h0);
		rd(`ACC_COUNT_ADDR, 32'h0);
		rd(`TIMER_CONTROL_ADDR, 32'h0);
		rd(12'h0F0, 32'h0);
		wr(`ACC_CONTROL_ADDR, 32'hFF);
		rd(`ACC_CONTROL_ADDR, 32'h7F);
		$display("test registers done");
		// event counting on both edges, timer off
		for (int e = 0; e < 2; e++) begin
			pin_src.level(!e, 4);
			wr(`ACC_CONTROL_ADDR, 32'h41 | (e << 4));
			wr(`ACC_FLAGS_ADDR, 32'h03);
			v = 16'($urandom_range(0, 32'hFFF0));
			wr(`ACC_COUNT_ADDR, {16'h0, v});
			n = $urandom_range(1, 8);
			repeat (n) begin
				pin_src.level(e, 4);
				pin_src.level(!e, 4);
			end
			pin_src.level(e, 6);
			rd(`ACC_COUNT_ADDR, v + n + 1);
			rd(`ACC_FLAGS_ADDR, 32'h01);
			check("input irq", 32'h1, inIrq);
		end
		$display("test event counting done");
		// rollover, flag clearing, fast clear
		wr(`ACC_CONTROL_ADDR, 32'h42);
		wr(`ACC_FLAGS_ADDR, 32'h03);
		wr(`ACC_COUNT_ADDR, 32'hFFFF);
		pin_src.level(1'b0, 4);
		pin_src.level(1'b1, 4);
		rd(`ACC_COUNT_ADDR, 32'h0);
		rd(`ACC_FLAGS_ADDR, 32'h03);
		check("overflow irq", 32'h1, ovfIrq);
		check("input irq", 32'h0, inIrq);
		wr(`ACC_FLAGS_ADDR, 32'h0);
		rd(`ACC_FLAGS_ADDR, 32'h03);
		wr(`ACC_FLAGS_ADDR, 32'h02);
		rd(`ACC_FLAGS_ADDR, 32'h01);
		check("overflow irq", 32'h0, ovfIrq);
		wr(`TIMER_CONTROL_ADDR, 32'h10);
		rd(`ACC_COUNT_ADDR, 32'h0);
		rd(`ACC_FLAGS_ADDR, 32'h0);
		$display("test overflow and flags done");
		// gated accumulation, both levels, timer off then on
		for (int t = 0; t < 2; t++)
			for (int e = 0; e < 2; e++) begin
				pin_src.level(e, 4);
				wr(`TIMER_CONTROL_ADDR, t ? 32'h80 : 32'h00);
				wr(`ACC_CONTROL_ADDR, 32'h60 | (e << 4));
				wr(`ACC_FLAGS_ADDR, 32'h03);
				wr(`ACC_COUNT_ADDR, 32'h0);
				pin_src.level(!e, 639);
				pin_src.level(e, 6);
				rd(`ACC_COUNT_ADDR, t * 10);
				if (t)
					rd(`ACC_FLAGS_ADDR, 32'h01);
			end
		$display("test gated accumulation done");
		// prescaler divides while the accumulator is off
		pin_src.level(1'b1, 4);
		wr(`ACC_CONTROL_ADDR, 32'h0C);
		for (int p = 0; p < 8; p++) begin
			wr(`TIMER_CONTROL_ADDR, 32'h80 | p);
			repeat (300) @(posedge clk_sys);
			tickStart();
			repeat (128) @(posedge clk_sys);
			tickCheck(128 >> p);
		end
		// accumulator clock and its divided form
		for (int c = 1; c < 3; c++) begin
			wr(`ACC_CONTROL_ADDR, 32'h40 | (c << 2));
			tickStart();
			repeat (3) begin
				pin_src.level(1'b0, 4);
				pin_src.level(1'b1, 4);
			end
			tickCheck(c == 1 ? 3 : 0);
		end
		$display("test clock select done");
		// clock enable low freezes the pin path and the counter
		wr(`ACC_CONTROL_ADDR, 32'h40);
		wr(`ACC_COUNT_ADDR, 32'h1234);
		@(posedge clk_sys);
		clkEn <= 1'b0;
		pin_src.level(1'b0, 4);
		pin_src.level(1'b1, 4);
		clkEn <= 1'b1;
		pin_src.level(1'b1, 4);
		rd(`ACC_COUNT_ADDR, 32'h1234);
		$display("test clock enable done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
